// >>> hw/mhsp_pkg.sv
/*
 * Shared constants and types for the modem-handshake serial port:
 * line timing, frame layout, the escape code, state encodings and the
 * structs that carry modem pins, straps and received characters.
 * Assumes a 100 MHz system clock; the bit rate is the internal baud rate.
 */
package mhsp_pkg;

    // System clock and internal baud timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYCLES = CLOCK_HZ / BAUD_RATE; // Nearest-below whole cycle count

    // Frame layout: start bit, data bits least significant first, stop bit
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 10;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;

    // Line levels
    localparam logic MARK = 1'b1;
    localparam logic SPACE = 1'b0;

    // Escape sequences: the escape code plus one following code
    localparam logic [7:0] ESC_CODE = 8'h1B;
    localparam logic [1:0] ESC_SEQ_LEN = 2'h2;

    // Terminal-ready level, driven as a constant
    localparam logic TERM_READY_ON = 1'b1;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } mhsp_tx_e;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_DATA = 2'b01,
        RX_STOP = 2'b10
    } mhsp_rx_e;

    // Control inputs from the data set, not yet synchronised
    typedef struct packed {
        logic clear_to_send;
        logic carrier_detect;
        logic tx_timing;
    } mhsp_modem_in_s;

    // Outputs toward the data set
    typedef struct packed {
        logic txd;
        logic request_to_send;
        logic terminal_ready;
    } mhsp_modem_out_s;

    // Board straps, high when fitted
    typedef struct packed {
        logic ext_clock;
        logic local_escape;
    } mhsp_strap_s;

    typedef struct packed {
        logic [7:0] data;
        logic frame_err;
    } mhsp_rx_char_s;

endpackage

// >>> hw/mhsp_port.sv
/*
 * Modem-handshake serial port: transmit gating, request-to-send and
 * terminal-ready control, escape filtering, bit timing selection and a
 * receiver clocked by the data set's receive element timing.
 * Assumes a data set on RS-232 circuits; pins arrive unsynchronised and
 * rxd is aligned to rx_clock, which the data set supplies.
 */
`timescale 1ns/100ps
// Notes on behaviour
// - Transmit line rests at mark between characters and when idle.
// - Request-to-send is on while a character waits or is being sent.
// - Shifting starts only with request-to-send, clear-to-send, terminal-ready all on.
// - Terminal-ready is held on continuously from power-up.
// - Escape sequences are sent unless the local-escape strap is fitted.
// - Transmit bits time from internal baud, or from the data set's transmit timing when strapped.
module mhsp_port
    import mhsp_pkg::*;
#(
    parameter int BIT_CYCLES_P = BIT_CYCLES
) (
    // System clock, reset and enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Link receive clock from the data set
    input wire logic rx_clock,
    // Characters to transmit
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_dropped,
    // Received characters
    output logic rx_valid,
    output mhsp_rx_char_s rx_char,
    // Straps
    input wire mhsp_strap_s straps,
    // Modem circuits
    input wire mhsp_modem_in_s modem_in,
    input wire logic rxd,
    output mhsp_modem_out_s modem_out,
    output logic out_clock
);

    localparam int DIV_W = $clog2(BIT_CYCLES_P);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES_P - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BIT_CYCLES_P / 2);

    // Synchronised pins
    logic [3:0] pins_s;
    wire cts_s = pins_s[3];
    wire timing_s = pins_s[2];
    wire ext_s = pins_s[1];
    wire local_esc_s = pins_s[0];

    mhsp_sync #(.WIDTH(4)) u_pin_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clock_en(clock_en),
        .d({modem_in.clear_to_send, modem_in.tx_timing, straps.ext_clock,
            straps.local_escape}),
        .q(pins_s)
    );

    // Transmit state
    mhsp_tx_e tx_state;
    logic [DIV_W-1:0] div_cnt;
    logic timing_prev;
    logic hold_full;
    logic [7:0] hold_data;
    logic [8:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] esc_left;
    logic rts;
    logic txd;

    // Bit timing selection
    wire int_tick = (div_cnt == DIV_LAST);
    wire ext_tick = timing_s & ~timing_prev;
    wire bit_tick = ext_s ? ext_tick : int_tick;

    // Escape filter decode
    wire accept = tx_valid & tx_ready;
    wire is_esc = (tx_data == ESC_CODE);
    wire in_esc = (esc_left != 2'h0);
    wire drop_now = local_esc_s & (is_esc | in_esc);
    wire load = accept & ~drop_now;
    wire [1:0] next_esc_left = is_esc ? ESC_SEQ_LEN - 2'h1 : esc_left - 2'h1;

    // Handshake gate; terminal-ready is a constant on
    wire busy = (tx_state == TX_SHIFT);
    wire all_on = rts & cts_s & TERM_READY_ON;
    wire start = hold_full & ~busy & all_on & bit_tick;
    wire last_bit = busy & bit_tick & (bit_cnt == TX_LAST_BIT);
    wire next_rts = hold_full | busy;

    // Only one character can wait; a second one stalls the user
    assign tx_ready = ~hold_full;

    // Internal baud divider and the clock driven out to the data set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            out_clock <= 1'b0;
            timing_prev <= 1'b0;
        end else if (clock_en) begin
            div_cnt <= int_tick ? '0 : div_cnt + DIV_W'(1);
            out_clock <= (div_cnt >= DIV_HALF);
            timing_prev <= timing_s;
        end
    end

    // Escape sequence tracking; dropped codes report a pulse
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            esc_left <= 2'h0;
            tx_dropped <= 1'b0;
        end else if (clock_en) begin
            tx_dropped <= accept & drop_now;
            if (accept && local_esc_s && (is_esc || in_esc)) begin
                esc_left <= next_esc_left;
            end else if (accept) begin
                esc_left <= 2'h0;
            end
        end
    end

    // Holding register and request-to-send
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_full <= 1'b0;
            hold_data <= 8'h00;
            rts <= 1'b0;
        end else if (clock_en) begin
            rts <= next_rts;
            if (load) begin
                hold_full <= 1'b1;
                hold_data <= tx_data;
            end else if (start) begin
                hold_full <= 1'b0;
            end
        end
    end

    // Shifter; once started it ignores the handshake lines until the stop bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_state <= TX_IDLE;
            shift <= '1;
            bit_cnt <= 4'h0;
            txd <= MARK;
        end else if (clock_en) begin
            unique case (tx_state)
                TX_IDLE: begin
                    if (start) begin
                        tx_state <= TX_SHIFT;
                        shift <= {MARK, hold_data};
                        bit_cnt <= 4'h0;
                        txd <= SPACE;
                    end else begin
                        txd <= MARK;
                    end
                end
                TX_SHIFT: begin
                    if (last_bit) begin
                        tx_state <= TX_IDLE;
                        txd <= MARK;
                    end else if (bit_tick) begin
                        txd <= shift[0];
                        shift <= {MARK, shift[8:1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    assign modem_out.txd = txd;
    assign modem_out.request_to_send = rts;
    assign modem_out.terminal_ready = TERM_READY_ON;

    // Receiver on the data set's receive timing clock
    mhsp_rx_e rx_state;
    logic carrier_s;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    mhsp_rx_char_s rx_word;
    logic rx_toggle;

    mhsp_sync #(.WIDTH(1)) u_carrier_sync (
        .clock(rx_clock),
        .reset_n(reset_n),
        .clock_en(1'b1),
        .d(modem_in.carrier_detect),
        .q(carrier_s)
    );

    // One sample per timing edge; a start bit counts only with carrier
    always_ff @(posedge rx_clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= RX_HUNT;
            rx_shift <= 8'h00;
            rx_cnt <= 3'h0;
            rx_word <= '0;
            rx_toggle <= 1'b0;
        end else begin
            unique case (rx_state)
                RX_HUNT: begin
                    if (carrier_s && rxd == SPACE) begin
                        rx_state <= RX_DATA;
                        rx_cnt <= 3'h0;
                    end
                end
                RX_DATA: begin
                    rx_shift <= {rxd, rx_shift[7:1]};
                    rx_cnt <= rx_cnt + 3'h1;
                    if (rx_cnt == RX_LAST_BIT) begin
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    rx_word <= '{data: rx_shift, frame_err: (rxd != MARK)};
                    rx_toggle <= ~rx_toggle;
                    rx_state <= RX_HUNT;
                end
                default: begin
                    rx_state <= RX_HUNT;
                end
            endcase
        end
    end

    // Toggle crossing; the word is stable a whole frame before it changes
    logic toggle_s;
    logic toggle_prev;

    mhsp_sync #(.WIDTH(1)) u_toggle_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clock_en(clock_en),
        .d(rx_toggle),
        .q(toggle_s)
    );

    wire rx_event = toggle_s ^ toggle_prev;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            toggle_prev <= 1'b0;
            rx_valid <= 1'b0;
            rx_char <= '0;
        end else if (clock_en) begin
            toggle_prev <= toggle_s;
            rx_valid <= rx_event;
            if (rx_event) begin
                rx_char <= rx_word;
            end
        end
    end

    // Checks and covers on the transmit side and a cover on the receive side
    chk_idle_mark: assert property (@(posedge clock) disable iff (!reset_n)
        (!busy && $past(!busy)) |-> txd == MARK)
        else $error("transmit line left mark while idle");

    chk_rts_follows: assert property (@(posedge clock) disable iff (!reset_n)
        clock_en |=> rts == $past(hold_full | busy))
        else $error("request-to-send does not track pending data");

    chk_start_gate: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> $past(rts && cts_s) && txd == SPACE)
        else $error("character started without full handshake");

    chk_ready_high: assert property (@(posedge clock) disable iff (!reset_n)
        modem_out.terminal_ready == 1'b1)
        else $error("terminal-ready dropped");

    chk_esc_dropped: assert property (@(posedge clock) disable iff (!reset_n)
        (clock_en && accept && local_esc_s && is_esc) |=> tx_dropped && !hold_full)
        else $error("escape code reached the line with strap fitted");

    chk_internal_tick: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && $past(busy) && $past(!ext_s) && $changed(bit_cnt))
            |-> $past(div_cnt) == DIV_LAST)
        else $error("internal bit timing not from the divider");

    chk_char_finish: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(busy) |-> $past(bit_cnt) == TX_LAST_BIT && txd == MARK)
        else $error("character cut short");

    chk_no_abort: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && !cts_s && !bit_tick) |=> busy)
        else $error("handshake drop aborted a character");

    cov_frame_sent: cover property (@(posedge clock) disable iff (!reset_n)
        $fell(busy));

    cov_cts_mid_char: cover property (@(posedge clock) disable iff (!reset_n)
        busy && $fell(cts_s));

    cov_esc_drop: cover property (@(posedge clock) disable iff (!reset_n)
        tx_dropped);

    cov_rx_char: cover property (@(posedge clock) disable iff (!reset_n)
        rx_valid && !rx_char.frame_err);

endmodule

// >>> hw/mhsp_sync.sv
/*
 * Two-flop level synchroniser, one stage pair per bit.
 * Assumes d comes from another clock or a pin; only q may be read.
 */
`timescale 1ns/100ps
module mhsp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            q <= '0;
        end else if (clock_en) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// >>> test/mhsp_data_set.sv
/*
 * Behavioural data set on the far side of the serial port.
 * Assumes the bench sets carrier_on and cts_hold and calls send.
 */
`timescale 1ns/100ps
module mhsp_data_set
    import mhsp_pkg::*;
#(
    parameter int CTS_DELAY_NS = 400,
    parameter int TT_HALF_NS = 160
) (
    // From the port
    input wire mhsp_modem_out_s modem_out,
    // Bench controls
    input wire logic carrier_on,
    input wire logic cts_hold,
    // Toward the port
    output mhsp_modem_in_s modem_in,
    output logic rxd,
    output logic rx_clock
);
    logic cts_ready = 1'b0;
    logic tt = 1'b0;

    // Connection set-up delay before clear-to-send; drop with rts
    always @(modem_out.request_to_send) begin
        if (modem_out.request_to_send) begin
            #(CTS_DELAY_NS);
            cts_ready = modem_out.request_to_send;
        end else begin
            cts_ready = 1'b0;
        end
    end
    assign modem_in.clear_to_send = cts_ready & ~cts_hold;
    assign modem_in.carrier_detect = carrier_on;
    // Transmit timing only while in transmit state
    always #(TT_HALF_NS) tt = modem_out.request_to_send ? ~tt : 1'b0;
    assign modem_in.tx_timing = tt;
    // Receive timing stands still without carrier
    initial rx_clock = 1'b0;
    always #80 rx_clock = carrier_on ? ~rx_clock : 1'b0;
    initial rxd = MARK;

    // One character, bits change on the falling edge
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, SPACE};
        for (int i = 0; i < 10; i++) begin
            @(negedge rx_clock);
            rxd = f[i];
        end
        @(negedge rx_clock);
        rxd = MARK;
    endtask
endmodule

// >>> test/mhsp_port_tb_top.sv
/*
 * Self-checking bench for the serial port with a data set model.
 * Assumes the port's bit count parameter is set short for speed.
 */
`timescale 1ns/100ps
`define CHK(nm, exp, seen) begin checked++; if ((seen) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, seen); end end
module mhsp_port_tb_top;
    import mhsp_pkg::*;
    localparam int BC = 16;
    logic clock = 1'b0, clock_en = 1'b1, tx_valid = 1'b0;
    logic reset_n;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready, tx_dropped, rx_valid, rxd, rx_clock, out_clock;
    logic carrier_on = 1'b1, cts_hold = 1'b0;
    mhsp_rx_char_s rx_char, got;
    mhsp_strap_s straps = '0;
    mhsp_modem_in_s modem_in;
    mhsp_modem_out_s modem_out;
    int errors = 0, checked = 0, cycles = 0, drops = 0, lows = 0, rx_cnt = 0;

    mhsp_port #(.BIT_CYCLES_P(BC)) u_mhsp_port (.clock(clock), .reset_n(reset_n),
        .clock_en(clock_en), .rx_clock(rx_clock), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_dropped(tx_dropped), .rx_valid(rx_valid),
        .rx_char(rx_char), .straps(straps), .modem_in(modem_in), .rxd(rxd),
        .modem_out(modem_out), .out_clock(out_clock));
    mhsp_data_set u_mhsp_data_set (.modem_out(modem_out), .carrier_on(carrier_on),
        .cts_hold(cts_hold), .modem_in(modem_in), .rxd(rxd), .rx_clock(rx_clock));

    always #5 clock = ~clock;
    // Event counters; a hang past the ceiling counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (tx_dropped === 1'b1) drops++;
        if (modem_out.txd === 1'b0) lows++;
        if (rx_valid === 1'b1) begin
            rx_cnt++;
            got = rx_char;
        end
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Offer one code and hold it until taken
    task automatic offer(input logic [7:0] b);
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_data <= b;
        do @(negedge clock); while (tx_ready !== 1'b1);
        @(posedge clock);
        tx_valid <= 1'b0;
    endtask

    // Sample one line frame mid-bit; optionally drop cts at a bit
    task automatic grab(input int bc, input int drop_bit, input logic [7:0] b);
        logic [9:0] f;
        int n;
        int rl;
        n = 0;
        rl = 0;
        while (modem_out.txd !== 1'b0 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        repeat (bc / 2) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            f[i] = modem_out.txd;
            if (modem_out.request_to_send !== 1'b1) rl++;
            if (i == drop_bit) cts_hold = 1'b1;
            if (i < 9) repeat (bc) @(negedge clock);
        end
        `CHK("frame", {MARK, b, SPACE}, f)
        `CHK("rts_in_frame", 0, rl)
    endtask

    task automatic t_reset();
        `CHK("txd_idle", MARK, modem_out.txd)
        `CHK("rts_idle", 1'b0, modem_out.request_to_send)
        `CHK("term_ready", 1'b1, modem_out.terminal_ready)
    endtask

    task automatic t_gate();
        int l;
        cts_hold <= 1'b1;
        l = lows;
        offer(8'hA5);
        repeat (300) @(posedge clock);
        `CHK("rts_pending", 1'b1, modem_out.request_to_send)
        `CHK("no_shift", l, lows)
        cts_hold <= 1'b0;
        grab(BC, 99, 8'hA5);
        repeat (BC) @(negedge clock);
        `CHK("rts_done", 1'b0, modem_out.request_to_send)
        `CHK("txd_after", MARK, modem_out.txd)
        `CHK("term_ready_run", 1'b1, modem_out.terminal_ready)
    endtask

    task automatic t_drop();
        int l;
        fork
            begin
                offer(8'h5A);
                offer(8'hC3);
                offer(8'h96);
            end
        join_none
        grab(BC, 99, 8'h5A);
        grab(BC, 4, 8'hC3);
        l = lows;
        repeat (200) @(posedge clock);
        `CHK("held_mark", l, lows)
        `CHK("rts_waiting", 1'b1, modem_out.request_to_send)
        cts_hold <= 1'b0;
        grab(BC, 99, 8'h96);
        repeat (BC) @(posedge clock);
    endtask

    task automatic t_escape();
        int d;
        int l;
        @(posedge clock) straps.local_escape <= 1'b1;
        repeat (4) @(posedge clock);
        d = drops;
        l = lows;
        offer(ESC_CODE);
        offer(8'h41);
        repeat (100) @(posedge clock);
        `CHK("dropped", 2, drops - d)
        `CHK("esc_local", l, lows)
        @(posedge clock) straps.local_escape <= 1'b0;
        repeat (4) @(posedge clock);
        offer(ESC_CODE);
        grab(BC, 99, ESC_CODE);
    endtask

    task automatic t_ext();
        @(posedge clock) straps.ext_clock <= 1'b1;
        repeat (4) @(posedge clock);
        offer(8'h69);
        grab(32, 99, 8'h69);
        repeat (40) @(posedge clock);
        straps.ext_clock <= 1'b0;
    endtask

    // Baud clock out: half high over whole periods; frozen while disabled
    task automatic t_clk();
        int hi;
        int rises;
        logic last;
        hi = 0;
        rises = 0;
        @(negedge clock);
        last = out_clock;
        for (int i = 0; i < 4 * BC; i++) begin
            @(negedge clock);
            if (out_clock === 1'b1) hi++;
            if (out_clock === 1'b1 && last === 1'b0) rises++;
            last = out_clock;
        end
        `CHK("clk_high", 2 * BC, hi)
        `CHK("clk_rises", 4, rises)
        @(posedge clock);
        clock_en <= 1'b0;
        rises = 0;
        @(negedge clock);
        last = out_clock;
        repeat (3 * BC) begin
            @(negedge clock);
            if (out_clock !== last) rises++;
        end
        `CHK("clk_frozen", 0, rises)
        @(posedge clock);
        clock_en <= 1'b1;
    endtask

    task automatic t_rx(input logic [7:0] b, input logic stop);
        int n;
        n = rx_cnt;
        u_mhsp_data_set.send(b, stop);
        repeat (20) @(posedge clock);
        `CHK("rx_count", n + 1, rx_cnt)
        `CHK("rx_data", b, got.data)
        `CHK("rx_ferr", ~stop, got.frame_err)
    endtask

    // Reset starts from unknown so the link-side flops also see its edge
    initial begin
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_gate();
        t_drop();
        t_escape();
        t_ext();
        t_clk();
        t_rx(8'h3C, 1'b1);
        t_rx(8'hA1, 1'b0);
        summarize();
    end
endmodule
